// ---- common/sync_monitor_defines.vh ----
`ifndef SYNC_MONITOR_DEFINES_VH
`define SYNC_MONITOR_DEFINES_VH

// ****************************************************************
// clock and timing
// ****************************************************************
`define CLK_MHZ 32'h0000_0032
`define CLK_NS (32'h0000_03e8 / `CLK_MHZ)

// ****************************************************************
// register byte offsets
// ****************************************************************
`define A_MODE 8'h00
`define A_CYCLE 8'h04
`define A_SHIFT 8'h08
`define A_SUPP 8'h0c
`define A_MINCYC 8'h10
`define A_CALC 8'h14
`define A_MINDLY 8'h18
`define A_CMD 8'h1c
`define A_MAXDLY 8'h20
`define A_MISSED 8'h24
`define A_OVERRUN 8'h28
`define A_SHORT 8'h2c
`define A_LATE 8'h30
`define A_IN_SHIFT 8'h34
`define A_IN_DELAY 8'h38
`define A_IRQ_STAT 8'h3c
`define A_IRQ_MASK 8'h40

// ****************************************************************
// reset values
// ****************************************************************
`define R_MODE 2'h1
`define R_CYCLE 32'h000f_4240
`define R_SUPP 16'hc007
`define R_MINCYC 32'h0003_d090
`define R_ZERO32 32'h0000_0000
`define R_CMD 16'h0000

// ****************************************************************
// supported-modes fields and mode codes
// ****************************************************************
`define SUP_FREE_BIT 0
`define SUP_SM_BIT 1
`define SUP_DC_LSB 2
`define SUP_DC_VAL 2'h1
`define SUP_SHIFT_LSB 4
`define SUP_SHIFT_S1 2'h2
`define SUP_DYN_BIT 14
`define MODE_FREE 2'h0
`define MODE_SM 2'h1
`define MODE_DC0 2'h2
`define MODE_DC1 2'h3
`define CMD_START 16'h0001

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define IRQ_MISSED 0
`define IRQ_OVERRUN 1
`define IRQ_SHORT 2
`define IRQ_LATE 3
`define IRQ_W 4

`endif

// ---- rtl/sat_count16.v ----
`timescale 1ns/1ps
// saturating 16-bit event counter, holds at the top instead of wrapping
module sat_count16 (
	// clock, enable, reset
	input wire clock,
	input wire ce,
	input wire rst_n,
	// event
	input wire inc,
	// value
	output reg [15:0] count_q
);

	// stop at all ones so a flood of errors never reads as a clean zero
	always @(posedge clock) begin
		if (!rst_n) begin
			count_q <= 16'h0000;
		end else if (ce && inc && (count_q != 16'hffff)) begin
			count_q <= count_q + 16'h0001;
		end
	end

endmodule // sat_count16

// ---- rtl/sync_monitor.v ----
// Functional notes
// - supported-modes bit0 free run, bit1 sm2 event, bits 2-3 = 01 dc mode
// - supported-modes bits 4-5 = 10 mean output shift with sync1, dc only
// - supported-modes bit 14 set: times are dynamic, measured via command
// - minimum cycle time read-only 32-bit in ns, default 250000
// - calc-and-copy reports least sync0 to sync1 time in ns, dc only
// - command write 1 starts measurement, 0 stops; host picks the moments
// - while measuring, shift, min cycle, calc, max delay and input times keep maxima
// - starting a new measurement clears earlier maxima first
// - maximum delay is sync1 to outputs driven in ns, dc only
// - 16-bit count of sm events missed in operational, dc only, from zero
// - 16-bit count of cycles overrun or next cycle too early, in operational
// - 16-bit count of sync0 to sync1 intervals too short, dc only
// - late-output flag set when last cycle drove outputs too late, dc only
// - mode codes: 0 free run, 1 sm2 event, 2 dc sync0, 3 dc sync1
// - cycle time in ns: local timer, master cycle, or sync period by mode
`timescale 1ns/1ps
`include "sync_monitor_defines.vh"
module sync_monitor (
	// clock, enable, reset
	input wire clock,
	input wire ce,
	input wire rst_n,
	// axi4-lite write address and data
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	// axi4-lite write response
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	output reg [1:0] s_axi_bresp,
	// axi4-lite read
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	input wire [7:0] s_axi_araddr,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	// timing events, one-cycle pulses from same-clock logic, and the operational level
	input wire sync0_pulse,
	input wire sync1_pulse,
	input wire sm_event_pulse,
	input wire calc_done_pulse,
	input wire outputs_driven_pulse,
	input wire inputs_latched_pulse,
	input wire operational,
	// interrupt
	output wire irq
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function [31:0] sat_inc;
		input [31:0] a;
		begin
			sat_inc = (a > (32'hffff_ffff - `CLK_NS)) ? 32'hffff_ffff : a + `CLK_NS;
		end
	endfunction

	function [31:0] max32;
		input [31:0] a;
		input [31:0] b;
		begin
			max32 = (a > b) ? a : b;
		end
	endfunction

	function [31:0] wmerge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0] strb;
		integer i;
		begin
			wmerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					wmerge[i*8 +: 8] = dat[i*8 +: 8];
				end
			end
		end
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	reg [1:0] mode_q;
	reg [31:0] cycle_q;
	reg [15:0] cmd_q;
	reg [31:0] shift_q, mincyc_q, calc_q, maxdly_q, in_shift_q, in_delay_q;
	reg [31:0] t0_q, t1_q, tc_q, tf_q;
	reg busy_q, sm_seen_q, driven_q, started_q, late_q;
	reg [`IRQ_W-1:0] irq_stat_q, irq_mask_q;
	reg aw_got_q, w_got_q;
	reg [7:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire [15:0] missed_cnt, overrun_cnt, short_cnt;

	// read-only capability word, fixed at the documented reset image R_SUPP
	wire [15:0] supp_word = `R_SUPP;

	wire dc = mode_q[1];
	wire measuring = (cmd_q == `CMD_START);
	wire do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
	wire [7:0] wa = {awaddr_q[7:2], 2'b00};
	wire wr_cmd = do_write & (wa == `A_CMD);
	wire [31:0] cmd_mrg = wmerge({16'h0000, cmd_q}, wdata_q, wstrb_q);
	wire [15:0] cmd_new = cmd_mrg[15:0];
	// a start is a write of 1 while not already measuring
	wire meas_start = ce & wr_cmd & (cmd_new == `CMD_START) & ~measuring;

	// ****************************************************************
	// cycle start by mode
	// ****************************************************************
	// free run ticks once the local timer reaches the set period
	wire fr_tick = (cycle_q <= `CLK_NS) | (tf_q >= (cycle_q - `CLK_NS));
	reg cyc_start;
	always @* begin
		case (mode_q)
		`MODE_FREE: cyc_start = fr_tick;
		`MODE_SM: cyc_start = sm_event_pulse;
		`MODE_DC0: cyc_start = sync0_pulse;
		`MODE_DC1: cyc_start = sync1_pulse;
		default: cyc_start = 1'b0;
		endcase
	end

	// ****************************************************************
	// error events
	// ****************************************************************
	wire ev_missed = operational & dc & sync0_pulse & ~sm_seen_q;
	wire ev_overrun = operational & cyc_start & busy_q;
	wire ev_short = dc & sync1_pulse & (t0_q < calc_q);
	wire late_next = ~driven_q;
	wire late_upd = dc & cyc_start & started_q;
	wire ev_late = late_upd & late_next & ~late_q;

	// ****************************************************************
	// elapsed-time counters in ns
	// ****************************************************************
	// each restarts on its own event and saturates rather than wrapping
	always @(posedge clock) begin
		if (!rst_n) begin
			t0_q <= `R_ZERO32;
			t1_q <= `R_ZERO32;
			tc_q <= `R_ZERO32;
			tf_q <= `R_ZERO32;
		end else if (ce) begin
			t0_q <= sync0_pulse ? `R_ZERO32 : sat_inc(t0_q);
			t1_q <= sync1_pulse ? `R_ZERO32 : sat_inc(t1_q);
			tc_q <= cyc_start ? `R_ZERO32 : sat_inc(tc_q);
			tf_q <= (fr_tick || mode_q != `MODE_FREE) ? `R_ZERO32 : sat_inc(tf_q);
		end
	end

	// ****************************************************************
	// cycle bookkeeping
	// ****************************************************************
	// a new cycle start wins over a calc completion in busy_q in the same clock; an outputs-driven pulse wins over the start in driven_q
	always @(posedge clock) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			sm_seen_q <= 1'b0;
			driven_q <= 1'b0;
			started_q <= 1'b0;
			late_q <= 1'b0;
		end else if (ce) begin
			busy_q <= cyc_start | (busy_q & ~calc_done_pulse);
			sm_seen_q <= sm_event_pulse | (sm_seen_q & ~sync0_pulse);
			driven_q <= outputs_driven_pulse | (driven_q & ~cyc_start);
			if (cyc_start) begin
				started_q <= 1'b1;
			end
			if (!dc) begin
				late_q <= 1'b0;
			end else if (late_upd) begin
				late_q <= late_next;
			end
		end
	end

	// ****************************************************************
	// worst-case capture
	// ****************************************************************
	// only maxima are kept; a start wipes them so old runs do not leak in
	always @(posedge clock) begin
		if (!rst_n) begin
			shift_q <= `R_ZERO32;
			mincyc_q <= `R_MINCYC;
			calc_q <= `R_ZERO32;
			maxdly_q <= `R_ZERO32;
			in_shift_q <= `R_ZERO32;
			in_delay_q <= `R_ZERO32;
		end else if (meas_start) begin
			shift_q <= `R_ZERO32;
			mincyc_q <= `R_ZERO32;
			calc_q <= `R_ZERO32;
			maxdly_q <= `R_ZERO32;
			in_shift_q <= `R_ZERO32;
			in_delay_q <= `R_ZERO32;
		end else if (ce && measuring) begin
			if (dc && outputs_driven_pulse) begin
				shift_q <= max32(shift_q, t0_q);
				maxdly_q <= max32(maxdly_q, t1_q);
			end
			if (calc_done_pulse) begin
				mincyc_q <= max32(mincyc_q, tc_q);
			end
			if (dc && calc_done_pulse) begin
				calc_q <= max32(calc_q, t0_q);
			end
			if (dc && inputs_latched_pulse) begin
				in_shift_q <= max32(in_shift_q, t0_q);
				in_delay_q <= max32(in_delay_q, t1_q);
			end
		end
	end

	// ****************************************************************
	// error counters
	// ****************************************************************
	sat_count16 u_missed (
		.clock(clock),
		.ce(ce),
		.rst_n(rst_n),
		.inc(ev_missed),
		.count_q(missed_cnt)
	);

	sat_count16 u_overrun (
		.clock(clock),
		.ce(ce),
		.rst_n(rst_n),
		.inc(ev_overrun),
		.count_q(overrun_cnt)
	);

	sat_count16 u_short (
		.clock(clock),
		.ce(ce),
		.rst_n(rst_n),
		.inc(ev_short),
		.count_q(short_cnt)
	);

	// ****************************************************************
	// axi4-lite write path
	// ****************************************************************
	// address and data are taken separately, then applied together
	assign s_axi_awready = ce & ~aw_got_q & ~s_axi_bvalid;
	assign s_axi_wready = ce & ~w_got_q & ~s_axi_bvalid;

	wire w_map = (wa <= `A_IRQ_MASK);
	wire [`IRQ_W-1:0] ev_vec = {ev_late, ev_short, ev_overrun, ev_missed};
	wire [31:0] wd_strb = wmerge(32'h0000_0000, wdata_q, wstrb_q);
	wire [`IRQ_W-1:0] w1c = (do_write && wa == `A_IRQ_STAT) ?
		wd_strb[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

	always @(posedge clock) begin
		if (!rst_n) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= `R_ZERO32;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			mode_q <= `R_MODE;
			cycle_q <= `R_CYCLE;
			cmd_q <= `R_CMD;
			irq_stat_q <= {`IRQ_W{1'b0}};
			irq_mask_q <= {`IRQ_W{1'b0}};
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// a new event wins over a write-one-to-clear in the same clock
			irq_stat_q <= (irq_stat_q & ~w1c) | ev_vec;
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_map ? 2'h0 : 2'h3;
				case (wa)
				`A_MODE: mode_q <= wstrb_q[0] ? wd_strb[1:0] : mode_q;
				`A_CYCLE: cycle_q <= wmerge(cycle_q, wdata_q, wstrb_q);
				`A_CMD: cmd_q <= cmd_new;
				`A_IRQ_MASK: irq_mask_q <= wstrb_q[0] ? wd_strb[`IRQ_W-1:0] : irq_mask_q;
				default: ;
				endcase
			end
		end
	end

	// ****************************************************************
	// axi4-lite read path
	// ****************************************************************
	assign s_axi_arready = ce & ~s_axi_rvalid;
	wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	reg [31:0] rmux;
	reg rhit;

	// narrow registers read zero-extended in the low bits
	always @* begin
		rhit = 1'b1;
		case (ra)
		`A_MODE: rmux = {30'h0, mode_q};
		`A_CYCLE: rmux = cycle_q;
		`A_SHIFT: rmux = shift_q;
		`A_SUPP: rmux = {16'h0000, supp_word};
		`A_MINCYC: rmux = mincyc_q;
		`A_CALC: rmux = calc_q;
		`A_MINDLY: rmux = `R_ZERO32;
		`A_CMD: rmux = {16'h0000, cmd_q};
		`A_MAXDLY: rmux = maxdly_q;
		`A_MISSED: rmux = {16'h0000, missed_cnt};
		`A_OVERRUN: rmux = {16'h0000, overrun_cnt};
		`A_SHORT: rmux = {16'h0000, short_cnt};
		`A_LATE: rmux = {31'h0, late_q};
		`A_IN_SHIFT: rmux = in_shift_q;
		`A_IN_DELAY: rmux = in_delay_q;
		`A_IRQ_STAT: rmux = {28'h0, irq_stat_q};
		`A_IRQ_MASK: rmux = {28'h0, irq_mask_q};
		default: begin
			rmux = `R_ZERO32;
			rhit = 1'b0;
		end
		endcase
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= `R_ZERO32;
			s_axi_rresp <= 2'h0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rmux;
				s_axi_rresp <= rhit ? 2'h0 : 2'h3;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// level interrupt while any unmasked sticky bit is set
	assign irq = |(irq_stat_q & irq_mask_q);

endmodule // sync_monitor

// ---- verification/sync_monitor_checker.sv ----
`timescale 1ns/1ps
module sync_monitor_checker (
	// clock and reset
	input wire clock,
	input wire ce,
	input wire rst_n,
	// register bus
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	// interrupt
	input wire irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	reg [7:0] ar_q;
	// ****************************************************************
	// helper: address of the read under way
	// ****************************************************************
	always @(posedge clock) begin
		if (s_axi_arvalid && s_axi_arready && ce) ar_q <= s_axi_araddr;
	end
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	// both items taken at one edge: the write lands one edge later, bvalid shows the next
	AST_B_TIME: assert property (ce && s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	AST_R_TIME: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	AST_CE_FREEZE: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
		else $error("ready while clock enable low");
	AST_SUPP: assert property ($rose(s_axi_rvalid) && ar_q == 8'h0c |-> s_axi_rdata == 32'h0000_c007)
		else $error("supported modes word wrong");
	AST_UNMAP: assert property ($rose(s_axi_rvalid) && ar_q[7:2] > 6'h10 |-> s_axi_rresp == 2'h3
		&& s_axi_rdata == 32'h0000_0000) else $error("unmapped read not refused");
	// main scenarios reached
	COV_WR: cover property (s_axi_bvalid && s_axi_bready);
	COV_RD: cover property (s_axi_rvalid && s_axi_rready);
	COV_IRQ: cover property ($rose(irq));
endmodule // sync_monitor_checker

// ---- verification/fieldbus_master_model.sv ----
`timescale 1ns/1ps
module fieldbus_master_model (
	// clock
	input wire clock,
	// events toward the monitor
	output wire sync0_pulse,
	output wire sync1_pulse,
	output wire sm_event_pulse,
	output wire calc_done_pulse,
	output wire outputs_driven_pulse,
	output wire inputs_latched_pulse
);
	reg [5:0] ev_q = 6'h00;
	// every event is a single-cycle pulse on the monitor's clock
	assign {inputs_latched_pulse, outputs_driven_pulse, calc_done_pulse} = ev_q[5:3];
	assign {sm_event_pulse, sync1_pulse, sync0_pulse} = ev_q[2:0];
	// one pulse then a quiet edge, so back-to-back calls never merge
	task fire(input [5:0] e);
		begin
			@(posedge clock);
			ev_q <= e;
			@(posedge clock);
			ev_q <= 6'h00;
		end
	endtask
endmodule // fieldbus_master_model

// ---- verification/sync_monitor_tb.sv ----
`timescale 1ns/1ps
module sync_monitor_tb;
	reg clock = 0, ce = 1, rst_n = 0, operational = 0;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	reg s_axi_arvalid = 0, s_axi_rready = 0;
	reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0, d, s1;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg [1:0] rs;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	wire e0, e1, e2, e3, e4, e5;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	integer fails = 0, n_tests = 0, i;
	sync_monitor dut (.clock(clock), .ce(ce), .rst_n(rst_n),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.sync0_pulse(e0), .sync1_pulse(e1), .sm_event_pulse(e2), .calc_done_pulse(e3),
		.outputs_driven_pulse(e4), .inputs_latched_pulse(e5), .operational(operational),
		.irq(irq));
	fieldbus_master_model m (.clock(clock), .sync0_pulse(e0), .sync1_pulse(e1),
		.sm_event_pulse(e2), .calc_done_pulse(e3), .outputs_driven_pulse(e4),
		.inputs_latched_pulse(e5));
	// 50 MHz clock
	initial begin
		forever #10 clock = ~clock;
	end
	// ****************************************************************
	// bus tasks and comparison
	// ****************************************************************
	task check(input [31:0] seen, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	// both channels offered together, each released at its own handshake
	task wr(input [7:0] a, input [31:0] v);
		begin
			s_axi_awvalid <= 1;
			s_axi_awaddr <= a;
			s_axi_wvalid <= 1;
			s_axi_wdata <= v;
			do begin
				@(posedge clock);
				if (s_axi_awready) s_axi_awvalid <= 0;
				if (s_axi_wready) s_axi_wvalid <= 0;
			end while (!s_axi_bvalid);
			// ready only once the answer shows, so the slave must hold it a cycle
			s_axi_bready <= 1;
			@(posedge clock);
			rs = s_axi_bresp;
			s_axi_bready <= 0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			s_axi_arvalid <= 1;
			s_axi_araddr <= a;
			@(posedge clock);
			while (!s_axi_arready) @(posedge clock);
			s_axi_arvalid <= 0;
			@(posedge clock);
			while (!s_axi_rvalid) @(posedge clock);
			s_axi_rready <= 1;
			@(posedge clock);
			d = s_axi_rdata;
			rs = s_axi_rresp;
			s_axi_rready <= 0;
		end
	endtask
	task stop_test;
		begin
			$display("comparisons %0d, mismatches %0d", n_tests, fails);
			if (fails == 0 && n_tests > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	// watchdog at 80000 cycles, beyond the roughly 66400 cycles the tests need
	initial begin
		#1600000;
		fails = fails + 1;
		stop_test;
	end
	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (10) @(posedge clock);
		rst_n <= 1;
		ce <= 0;
		repeat (3) @(posedge clock);
		ce <= 1;
		@(posedge clock);
		rd(8'h00); check(d, 32'h0000_0001);
		rd(8'h04); check(d, 32'h000f_4240);
		rd(8'h0c); check(d, 32'h0000_c007);
		rd(8'h10); check(d, 32'h0003_d090);
		for (i = 8'h14; i <= 8'h40; i = i + 4) begin
			rd(i[7:0]); check(d, 32'h0000_0000);
		end
		rd(8'h44); check({30'h0, rs}, 32'h0000_0003);
		wr(8'h44, 32'h0000_0001); check({30'h0, rs}, 32'h0000_0003);
		wr(8'h0c, 32'h0000_0000); rd(8'h0c); check(d, 32'h0000_c007);
		wr(8'h10, 32'h0000_0000); rd(8'h10); check(d, 32'h0003_d090);
		$display("test reset values done");
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'h00, i); rd(8'h00); check(d, i);
		end
		wr(8'h04, 32'h0007_a120); rd(8'h04); check(d, 32'h0007_a120);
		s_axi_wstrb <= 4'h1;
		wr(8'h04, 32'hffff_ff55); rd(8'h04); check(d, 32'h0007_a155);
		s_axi_wstrb <= 4'hf;
		wr(8'h00, 32'h0000_0002);
		$display("test modes done");
		operational <= 1;
		m.fire(6'h01); m.fire(6'h01); m.fire(6'h04); m.fire(6'h01);
		rd(8'h24); check(d, 32'h0000_0002);
		rd(8'h28); check(d, 32'h0000_0002);
		rd(8'h30); check(d, 32'h0000_0001);
		wr(8'h40, 32'h0000_0001); check(irq, 32'h0000_0001);
		wr(8'h3c, 32'h0000_0001); @(posedge clock); check(irq, 32'h0000_0000);
		wr(8'h40, 32'h0000_0000);
		$display("test error counters done");
		wr(8'h1c, 32'h0000_0001); rd(8'h1c); check(d, 32'h0000_0001);
		m.fire(6'h01); repeat (5) @(posedge clock); m.fire(6'h10);
		rd(8'h08); check(d, 32'h0000_0078);
		m.fire(6'h01); m.fire(6'h10);
		rd(8'h08); check(d, 32'h0000_0078);
		m.fire(6'h01);
		rd(8'h30); check(d, 32'h0000_0000);
		wr(8'h1c, 32'h0000_0000); wr(8'h1c, 32'h0000_0001);
		rd(8'h08); check(d, 32'h0000_0000);
		$display("test measurement done");
		m.fire(6'h01); repeat (8) @(posedge clock); m.fire(6'h08);
		rd(8'h14); check(d, 32'h0000_00b4);
		rd(8'h10); check(d, 32'h0000_00b4);
		m.fire(6'h01); m.fire(6'h02);
		rd(8'h2c); check(d, 32'h0000_0001);
		m.fire(6'h02); repeat (3) @(posedge clock); m.fire(6'h10);
		rd(8'h20); check(d, 32'h0000_0050);
		m.fire(6'h03); repeat (2) @(posedge clock); m.fire(6'h20);
		rd(8'h34); check(d, 32'h0000_003c);
		rd(8'h38); check(d, 32'h0000_003c);
		$display("test dc timing done");
		// each other cycle-start source, with the previous cycle still busy
		wr(8'h00, 32'h0000_0003); rd(8'h28); s1 = d;
		m.fire(6'h02); rd(8'h28); check(d, s1 + 32'h0000_0001);
		wr(8'h00, 32'h0000_0001); rd(8'h28); s1 = d;
		m.fire(6'h04); rd(8'h28); check(d, s1 + 32'h0000_0001);
		wr(8'h04, 32'h0000_0064); wr(8'h00, 32'h0000_0000); rd(8'h28); s1 = d;
		repeat (17) @(posedge clock);
		rd(8'h28); check(d, s1 + 32'h0000_0004);
		// a one-clock period overruns every clock, enough to reach the top
		wr(8'h04, 32'h0000_0014); repeat (66000) @(posedge clock);
		rd(8'h28); check(d, 32'h0000_ffff);
		$display("test modes and saturation done");
		stop_test;
	end
endmodule // sync_monitor_tb
bind sync_monitor sync_monitor_checker chk (.clock(clock), .ce(ce), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .irq(irq));
